// file: hdl/gpx_port.sv
// General purpose port: pad drive, peripheral routing, interrupts, wake and retention.
// Assumes an AHB-Lite master, one system clock and level mode inputs from the power controller.
//
// Register access over AHB-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module gpx_port #(
	parameter int          NPINS     = gpx_pkg::NPINS,
	parameter int          NROUTES   = gpx_pkg::NROUTES,
	parameter int          FILT_CYC  = gpx_pkg::FILT_CYC,
	parameter logic [30:0] SHUT_MASK = gpx_pkg::SHUT_MASK_DEF
) (
	input  wire logic               clk,                  // System clock, 25 MHz.
	input  wire logic               reset,                // Asynchronous reset, active high.
	input  wire logic               hsel,                 // Slave select.
	input  wire logic [31:0]        haddr,                // Byte address.
	input  wire logic [1:0]         htrans,               // Transfer type.
	input  wire logic               hwrite,               // Write when high.
	input  wire logic [2:0]         hsize,                // Transfer size, word only.
	input  wire logic [31:0]        hwdata,               // Write data.
	input  wire logic               hready,               // Bus ready in.
	output logic                    hreadyout,            // Always ready.
	output logic                    hresp,                // Always OKAY.
	output logic [31:0]             hrdata,               // Read data.
	input  wire logic [NPINS-1:0]   pad_in,               // Pad input levels.
	output logic [NPINS-1:0]        pad_out,              // Pad output levels.
	output logic [NPINS-1:0]        pad_oe,               // Pad output enables.
	input  wire logic [NROUTES-1:0] per_out,              // Peripheral output levels.
	input  wire logic [NROUTES-1:0] per_oe,               // Peripheral output enables.
	output logic [NROUTES-1:0]      per_in,               // Levels of routed pins.
	output logic [NPINS-1:0]        reflex_event_network, // Conditioned pin levels.
	input  wire logic               deep_sleep_mode,      // Device in deep sleep.
	input  wire logic               stop_mode,            // Device in stop.
	input  wire logic               shutoff_mode,         // Device in shutoff.
	output logic                    wake_req,             // Wake from sleep or stop.
	output logic                    shutoff_wake,         // Wake from shutoff.
	output logic                    irq                   // Interrupt, level.
);
	localparam int PIN_W = gpx_pkg::PIN_W;

	logic [NPINS-1:0] dir;
	logic [NPINS-1:0] dout;
	logic [NPINS-1:0] od_en;
	logic [NPINS-1:0] os_en;
	logic [NPINS-1:0] filt_en;
	logic [NPINS-1:0] irise;
	logic [NPINS-1:0] ifall;
	logic [NPINS-1:0] iflag;
	logic [NPINS-1:0] imask;
	logic [NPINS-1:0] wake_en;
	logic [NPINS-1:0] wake_pol;
	logic [PIN_W-1:0] route_sel [NROUTES];
	logic [NROUTES-1:0] route_en;

	logic             wr_pend;
	logic [7:0]       wr_addr;
	logic             acc;
	logic [31:0]      rd_val;

	logic [NPINS-1:0] ovr;
	logic [NPINS-1:0] ovr_out;
	logic [NPINS-1:0] ovr_oe;
	logic [NPINS-1:0] next_out;
	logic [NPINS-1:0] next_oe;
	logic [NPINS-1:0] hold;
	logic [NPINS-1:0] wake_match;

	gpx_in_if #(.N(NPINS)) in_bus ();

	if (NPINS < 1 || NPINS > 31 || NROUTES < 1 || NROUTES > 8 || FILT_CYC < 1)
	begin : g_bad
		$error("gpx_port: unsupported pin count, route count or filter length.");
	end

	function automatic logic [1:0] drive(
		input logic d,
		input logic out_dir,
		input logic od,
		input logic os
	);
		// Result is {level, enable}.
		if (!out_dir)
			return 2'b00;
		if (od)
			return {1'b0, !d};
		if (os)
			return {1'b1, d};
		return {d, 1'b1};
	endfunction : drive

	function automatic logic wsel(
		input logic       pend,
		input logic [7:0] addr,
		input logic [7:0] off
	);
		return pend && addr == off;
	endfunction : wsel

	// Bus slave: zero wait states, address captured in the address phase.
	assign acc       = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end
		else
		begin
			wr_pend <= acc && hwrite;
			if (acc)
				wr_addr <= haddr[7:0];
		end
	end

	always_comb
	begin
		rd_val = gpx_pkg::RST_ZERO;
		unique case (haddr[7:0])
			gpx_pkg::OFF_DIR:    rd_val = 32'(dir);
			gpx_pkg::OFF_DOUT:   rd_val = 32'(dout);
			gpx_pkg::OFF_ODEN:   rd_val = 32'(od_en);
			gpx_pkg::OFF_OSEN:   rd_val = 32'(os_en);
			gpx_pkg::OFF_FILT:   rd_val = 32'(filt_en);
			gpx_pkg::OFF_DIN:    rd_val = 32'(in_bus.level);
			gpx_pkg::OFF_IRISE:  rd_val = 32'(irise);
			gpx_pkg::OFF_IFALL:  rd_val = 32'(ifall);
			gpx_pkg::OFF_IFLAG:  rd_val = 32'(iflag);
			gpx_pkg::OFF_IMASK:  rd_val = 32'(imask);
			gpx_pkg::OFF_WAKEN:  rd_val = 32'(wake_en);
			gpx_pkg::OFF_WAKPOL: rd_val = 32'(wake_pol);
			gpx_pkg::OFF_STATUS:
			begin
				rd_val[gpx_pkg::STAT_DEEP_BIT] = deep_sleep_mode;
				rd_val[gpx_pkg::STAT_STOP_BIT] = stop_mode;
				rd_val[gpx_pkg::STAT_SHUT_BIT] = shutoff_mode;
			end
			default:
			begin
				for (int k = 0; k < NROUTES; k++)
				begin
					if (haddr[7:0] == gpx_pkg::OFF_ROUTE0 + 8'(4 * k))
					begin
						rd_val[PIN_W-1:0]            = route_sel[k];
						rd_val[gpx_pkg::ROUTE_EN_BIT] = route_en[k];
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			hrdata <= gpx_pkg::RST_ZERO;
		else if (acc && !hwrite)
			hrdata <= rd_val;
		else
			hrdata <= gpx_pkg::RST_ZERO;
	end

	// Pin configuration registers.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			dir      <= '0;
			dout     <= '0;
			od_en    <= '0;
			os_en    <= '0;
			filt_en  <= '0;
			wake_en  <= '0;
			wake_pol <= '0;
		end
		else
		begin
			if (wsel(wr_pend, wr_addr, gpx_pkg::OFF_DIR))
				dir <= hwdata[NPINS-1:0];
			if (wsel(wr_pend, wr_addr, gpx_pkg::OFF_DOUT))
				dout <= hwdata[NPINS-1:0];
			if (wsel(wr_pend, wr_addr, gpx_pkg::OFF_ODEN))
				od_en <= hwdata[NPINS-1:0];
			if (wsel(wr_pend, wr_addr, gpx_pkg::OFF_OSEN))
				os_en <= hwdata[NPINS-1:0];
			if (wsel(wr_pend, wr_addr, gpx_pkg::OFF_FILT))
				filt_en <= hwdata[NPINS-1:0];
			if (wsel(wr_pend, wr_addr, gpx_pkg::OFF_WAKEN))
				wake_en <= hwdata[NPINS-1:0];
			if (wsel(wr_pend, wr_addr, gpx_pkg::OFF_WAKPOL))
				wake_pol <= hwdata[NPINS-1:0];
		end
	end

	// Routing registers: a selector and an enable per peripheral signal.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			route_en <= '0;
			for (int k = 0; k < NROUTES; k++)
				route_sel[k] <= '0;
		end
		else
		begin
			for (int k = 0; k < NROUTES; k++)
			begin
				if (wsel(wr_pend, wr_addr, gpx_pkg::OFF_ROUTE0 + 8'(4 * k)))
				begin
					route_sel[k] <= hwdata[PIN_W-1:0];
					route_en[k]  <= hwdata[gpx_pkg::ROUTE_EN_BIT];
				end
			end
		end
	end

	// Interrupt registers; a new event wins over a clear in the same cycle.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			irise <= '0;
			ifall <= '0;
			imask <= '0;
			iflag <= '0;
		end
		else
		begin
			if (wsel(wr_pend, wr_addr, gpx_pkg::OFF_IRISE))
				irise <= hwdata[NPINS-1:0];
			if (wsel(wr_pend, wr_addr, gpx_pkg::OFF_IFALL))
				ifall <= hwdata[NPINS-1:0];
			if (wsel(wr_pend, wr_addr, gpx_pkg::OFF_IMASK))
				imask <= hwdata[NPINS-1:0];
			iflag <= (iflag & ~(wsel(wr_pend, wr_addr, gpx_pkg::OFF_IFLAG)
				? hwdata[NPINS-1:0] : '0))
				| (in_bus.rise & irise) | (in_bus.fall & ifall);
		end
	end

	assign irq = |(iflag & imask);

	// Peripheral override; the lowest numbered route wins a shared pin.
	always_comb
	begin
		ovr     = '0;
		ovr_out = '0;
		ovr_oe  = '0;
		for (int p = 0; p < NPINS; p++)
		begin
			for (int k = NROUTES - 1; k >= 0; k--)
			begin
				if (route_en[k] && route_sel[k] == PIN_W'(p))
				begin
					ovr[p]     = 1'b1;
					ovr_out[p] = per_out[k];
					ovr_oe[p]  = per_oe[k];
				end
			end
		end
	end

	always_comb
	begin
		next_out = '0;
		next_oe  = '0;
		for (int p = 0; p < NPINS; p++)
		begin
			if (ovr[p])
			begin
				next_out[p] = ovr_out[p];
				next_oe[p]  = ovr_oe[p];
			end
			else
				{next_out[p], next_oe[p]} = drive(dout[p], dir[p], od_en[p], os_en[p]);
		end
	end

	// Ports C and D freeze in deep sleep and stop; ports A and B keep running.
	assign hold = (deep_sleep_mode || stop_mode) ? gpx_pkg::CD_MASK[NPINS-1:0] : '0;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			pad_out <= '0;
			pad_oe  <= '0;
		end
		else
		begin
			for (int p = 0; p < NPINS; p++)
			begin
				if (!hold[p])
				begin
					pad_out[p] <= next_out[p];
					pad_oe[p]  <= next_oe[p];
				end
			end
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			per_in <= '0;
		else
			for (int k = 0; k < NROUTES; k++)
				per_in[k] <= (32'(route_sel[k]) < NPINS) ? in_bus.level[route_sel[k]] : 1'b0;
	end

	assign in_bus.raw            = pad_in;
	assign in_bus.filt_en        = filt_en;
	assign reflex_event_network  = in_bus.level;

	gpx_inflt #(
		.N    (NPINS),
		.FILT (FILT_CYC)
	) u_inflt (
		.clk   (clk),
		.reset (reset),
		.io    (in_bus.cond)
	);

	// Wake paths are pure gates on the pads so they work with the clock stopped.
	assign wake_match   = wake_en & ~(pad_in ^ wake_pol);
	assign wake_req     = (deep_sleep_mode || stop_mode)
		&& |(wake_match & gpx_pkg::AB_MASK[NPINS-1:0]);
	assign shutoff_wake = shutoff_mode && |(wake_match & SHUT_MASK[NPINS-1:0]);

	property p_oe_off;
		@(posedge clk) disable iff (reset)
		(!dir[0] && !ovr[0]) |=> !pad_oe[0];
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("Input pin 0 drove its pad.");

	property p_open_drain;
		@(posedge clk) disable iff (reset)
		(dir[0] && od_en[0] && !ovr[0]) |=> (!pad_out[0] && pad_oe[0] == !$past(dout[0]));
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("Open-drain drive wrong.");

	property p_route;
		@(posedge clk) disable iff (reset)
		(route_en[0] && route_sel[0] == PIN_W'(1))
		|=> (pad_out[1] == $past(per_out[0]) && pad_oe[1] == $past(per_oe[0]));
	endproperty
	a_route: assert property (p_route) else $error("Routed peripheral lost pin 1.");

	property p_reflex;
		@(posedge clk) disable iff (reset)
		(pad_in[0] && !filt_en[0])[*4] |=> reflex_event_network[0];
	endproperty
	a_reflex: assert property (p_reflex) else $error("Pin level missing on network.");

	property p_irq;
		@(posedge clk) disable iff (reset)
		(|(in_bus.rise & irise & imask) && !wr_pend) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("Rising edge raised no interrupt.");

	property p_wake;
		@(posedge clk) disable iff (reset)
		(deep_sleep_mode && wake_en[3] && pad_in[3] == wake_pol[3]) |-> wake_req;
	endproperty
	a_wake: assert property (p_wake) else $error("Port A pin failed to wake.");

	property p_retain;
		@(posedge clk) disable iff (reset)
		deep_sleep_mode |=> ((pad_out ^ $past(pad_out)) & gpx_pkg::CD_MASK[NPINS-1:0]) == '0;
	endproperty
	a_retain: assert property (p_retain) else $error("Port C or D changed in sleep.");

	property p_shut;
		@(posedge clk) disable iff (reset)
		(!shutoff_mode || (wake_match & SHUT_MASK[NPINS-1:0]) == '0) |-> !shutoff_wake;
	endproperty
	a_shut: assert property (p_shut) else $error("Shutoff wake from a wrong pin.");
endmodule : gpx_port

// file: hdl/gpx_pkg.sv
// Constants shared by the general purpose port block and its input conditioner.
// Assumes a 25 MHz system clock and software access over an AHB-Lite slave port.
package gpx_pkg;
	localparam int          NPINS         = 31;
	localparam int          NROUTES       = 4;
	localparam int          PIN_W         = 5;
	localparam int          CLK_PERIOD_PS = 40000;
	localparam int          FILT_NS       = 100;
	localparam int          FILT_CYC      = (FILT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	localparam logic [7:0]  OFF_DIR       = 8'h00;
	localparam logic [7:0]  OFF_DOUT      = 8'h04;
	localparam logic [7:0]  OFF_ODEN      = 8'h08;
	localparam logic [7:0]  OFF_OSEN      = 8'h0c;
	localparam logic [7:0]  OFF_FILT      = 8'h10;
	localparam logic [7:0]  OFF_DIN       = 8'h14;
	localparam logic [7:0]  OFF_IRISE     = 8'h18;
	localparam logic [7:0]  OFF_IFALL     = 8'h1c;
	localparam logic [7:0]  OFF_IFLAG     = 8'h20;
	localparam logic [7:0]  OFF_IMASK     = 8'h24;
	localparam logic [7:0]  OFF_WAKEN     = 8'h28;
	localparam logic [7:0]  OFF_WAKPOL    = 8'h2c;
	localparam logic [7:0]  OFF_STATUS    = 8'h30;
	localparam logic [7:0]  OFF_ROUTE0    = 8'h40;

	localparam int          ROUTE_EN_BIT  = 8;
	localparam int          STAT_DEEP_BIT = 0;
	localparam int          STAT_STOP_BIT = 1;
	localparam int          STAT_SHUT_BIT = 2;

	localparam logic [30:0] AB_MASK       = 31'h0000ffff;
	localparam logic [30:0] CD_MASK       = 31'h7fff0000;
	localparam logic [30:0] SHUT_MASK_DEF = 31'h00000105;
	localparam logic [31:0] RST_ZERO      = 32'h00000000;
endpackage : gpx_pkg

// file: hdl/gpx_in_if.sv
// Interface between the port core and its input conditioner.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
interface gpx_in_if #(parameter int N = gpx_pkg::NPINS);
	logic [N-1:0] raw;
	logic [N-1:0] filt_en;
	logic [N-1:0] level;
	logic [N-1:0] rise;
	logic [N-1:0] fall;

	modport core (output raw, output filt_en, input level, input rise, input fall);
	modport cond (input raw, input filt_en, output level, output rise, output fall);
endinterface : gpx_in_if

// file: hdl/gpx_inflt.sv
// Pin input conditioner: three-stage synchroniser, optional glitch filter, edge pulses.
// Assumes raw pad levels that are asynchronous to clk.
`timescale 1ns/100ps
module gpx_inflt #(
	parameter int N    = gpx_pkg::NPINS,
	parameter int FILT = gpx_pkg::FILT_CYC
) (
	input  wire logic clk,     // System clock.
	input  wire logic reset,   // Asynchronous reset, active high.
	gpx_in_if.cond    io       // Raw levels in, conditioned levels out.
);
	localparam int CW = $clog2(FILT + 1);

	logic [N-1:0]  s1;
	logic [N-1:0]  s2;
	logic [N-1:0]  s3;
	logic [N-1:0]  lvl;
	logic [N-1:0]  rise;
	logic [N-1:0]  fall;
	logic [CW-1:0] cnt [N];

	if (N < 1 || N > 31 || FILT < 1)
	begin : g_bad
		$error("gpx_inflt: unsupported pin count or filter length.");
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end
		else
		begin
			s1 <= io.raw;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// A change counts once stages two and three agree; the filter then asks for FILT agreeing cycles.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			lvl  <= '0;
			rise <= '0;
			fall <= '0;
			for (int i = 0; i < N; i++)
				cnt[i] <= '0;
		end
		else
		begin
			for (int i = 0; i < N; i++)
			begin
				rise[i] <= 1'b0;
				fall[i] <= 1'b0;
				if (s2[i] != s3[i] || s3[i] == lvl[i])
					cnt[i] <= '0;
				else if (!io.filt_en[i] || cnt[i] == CW'(FILT - 1))
				begin
					lvl[i]  <= s3[i];
					rise[i] <= s3[i];
					fall[i] <= !s3[i];
					cnt[i]  <= '0;
				end
				else
					cnt[i] <= cnt[i] + CW'(1);
			end
		end
	end

	assign io.level = lvl;
	assign io.rise  = rise;
	assign io.fall  = fall;
endmodule : gpx_inflt

// file: tb/gpx_pad_model.sv
// Board side of the port pins: each pad shows the device's level while it drives,
// otherwise the level that the bench puts on the board wire.
// Assumes pad enables are active high while the device drives the pad.
`timescale 1ns/100ps
module gpx_pad_model #(
	parameter int N = gpx_pkg::NPINS
) (
	input  wire logic [N-1:0] pad_out,  // Device pad levels.
	input  wire logic [N-1:0] pad_oe,   // Device pad enables.
	input  wire logic [N-1:0] ext_val,  // Board drive levels.
	output logic [N-1:0]      pad_in    // Resolved wire levels.
);
	always_comb
	begin
		for (int i = 0; i < N; i++)
		begin
			pad_in[i] = pad_oe[i] ? pad_out[i] : ext_val[i];
		end
	end
endmodule : gpx_pad_model

// file: tb/test_gpx_port.sv
// Self-checking bench for the general purpose port, one task per scenario.
// Assumes the pad model closes the pins and the bench is the only bus master.
`timescale 1ns/100ps
module test_gpx_port;
	logic        clk, reset, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [30:0] pad_in, pad_out, pad_oe, ext_val, reflex_event_network;
	logic [3:0]  per_out, per_oe, per_in;
	logic        deep_sleep_mode, stop_mode, shutoff_mode, wake_req, shutoff_wake, irq;
	int          miscompares, n_tests, cycles;

	assign hready = hreadyout;

	gpx_port u_gpx_port (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .per_out(per_out), .per_oe(per_oe),
		.per_in(per_in), .reflex_event_network(reflex_event_network),
		.deep_sleep_mode(deep_sleep_mode), .stop_mode(stop_mode),
		.shutoff_mode(shutoff_mode), .wake_req(wake_req), .shutoff_wake(shutoff_wake),
		.irq(irq));
	gpx_pad_model u_gpx_pad_model (.pad_out(pad_out), .pad_oe(pad_oe), .ext_val(ext_val),
		.pad_in(pad_in));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task finish_test;
		$display("miscompares %0d n_tests %0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles > 5000)
		begin
			miscompares++;
			finish_test();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Both bus tasks start just after a rising edge and end on one.
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1)
			@(posedge clk);
		rd = hrdata;
	endtask : ahb

	// One idle cycle lets the written register settle before it is read or observed.
	task wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
		@(posedge clk);
	endtask : wr

	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h00000000);
		check(rd, exp);
	endtask : rdchk

	task wait_cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_cyc

	task t_reset;
		check({1'b0, pad_oe}, 32'h00000000);
		check({30'h0, hreadyout, hresp}, 32'h00000002);
		rdchk(gpx_pkg::OFF_DIR, 32'h00000000);
		rdchk(gpx_pkg::OFF_IFLAG, 32'h00000000);
		rdchk(gpx_pkg::OFF_STATUS, 32'h00000000);
		rdchk(8'h3c, 32'h00000000);
		check({31'h0, irq}, 32'h00000000);
		$display("reset done");
	endtask : t_reset

	task t_drive;
		wr(gpx_pkg::OFF_DIR, 32'h00000007);
		wr(gpx_pkg::OFF_ODEN, 32'h00000002);
		wr(gpx_pkg::OFF_OSEN, 32'h00000004);
		wr(gpx_pkg::OFF_DOUT, 32'h00000005);
		wait_cyc(2);
		check({28'h0, pad_oe[3:0]}, 32'h00000007);
		check({28'h0, pad_out[3:0]}, 32'h00000005);
		wr(gpx_pkg::OFF_DOUT, 32'h00000002);
		wait_cyc(2);
		check({28'h0, pad_oe[3:0]}, 32'h00000001);
		check({29'h0, pad_out[2:0]}, 32'h00000004);
		$display("drive done");
	endtask : t_drive

	task t_irq;
		wr(gpx_pkg::OFF_IRISE, 32'h00000020);
		wr(gpx_pkg::OFF_IFALL, 32'h00000020);
		wr(gpx_pkg::OFF_IMASK, 32'h00000020);
		ext_val[5] <= 1'b1;
		wait_cyc(6);
		check({31'h0, reflex_event_network[5]}, 32'h00000001);
		rdchk(gpx_pkg::OFF_DIN, 32'h00000020);
		check({31'h0, irq}, 32'h00000001);
		rdchk(gpx_pkg::OFF_IFLAG, 32'h00000020);
		wr(gpx_pkg::OFF_IMASK, 32'h00000000);
		check({31'h0, irq}, 32'h00000000);
		wr(gpx_pkg::OFF_IFLAG, 32'h00000020);
		rdchk(gpx_pkg::OFF_IFLAG, 32'h00000000);
		wr(gpx_pkg::OFF_IMASK, 32'h00000020);
		ext_val[5] <= 1'b0;
		wait_cyc(6);
		check({31'h0, irq}, 32'h00000001);
		wr(gpx_pkg::OFF_IFLAG, 32'h00000020);
		check({31'h0, irq}, 32'h00000000);
		$display("interrupt done");
	endtask : t_irq

	task t_filter;
		logic seen;
		seen = 1'b0;
		wr(gpx_pkg::OFF_FILT, 32'h00000040);
		ext_val[6] <= 1'b1;
		wait_cyc(2);
		ext_val[6] <= 1'b0;
		repeat (10)
		begin
			@(negedge clk);
			seen = seen | reflex_event_network[6];
		end
		check({31'h0, seen}, 32'h00000000);
		@(posedge clk);
		ext_val[6] <= 1'b1;
		wait_cyc(12);
		check({31'h0, reflex_event_network[6]}, 32'h00000001);
		$display("filter done");
	endtask : t_filter

	task t_route;
		int pin;
		for (int k = 0; k < 2; k++)
		begin
			pin = 1 + 10 * k;
			wr(gpx_pkg::OFF_ROUTE0 + 8'(4 * k), 32'h00000100 | 32'(pin));
			per_out[k] <= 1'b1;
			per_oe[k]  <= 1'b1;
			wait_cyc(3);
			check({30'h0, pad_oe[pin], pad_out[pin]}, 32'h00000003);
			per_out[k]   <= 1'b0;
			per_oe[k]    <= 1'b0;
			ext_val[pin] <= 1'b1;
			wait_cyc(7);
			check({31'h0, pad_oe[pin]}, 32'h00000000);
			check({31'h0, per_in[k]}, 32'h00000001);
		end
		$display("route done");
	endtask : t_route

	task t_wake;
		wr(gpx_pkg::OFF_WAKEN, 32'h00100108);
		wr(gpx_pkg::OFF_WAKPOL, 32'h00100108);
		ext_val[3] <= 1'b1;
		wait_cyc(1);
		check({31'h0, wake_req}, 32'h00000000);
		deep_sleep_mode <= 1'b1;
		wait_cyc(1);
		check({31'h0, wake_req}, 32'h00000001);
		deep_sleep_mode <= 1'b0;
		stop_mode       <= 1'b1;
		wait_cyc(1);
		check({31'h0, wake_req}, 32'h00000001);
		ext_val[3]  <= 1'b0;
		ext_val[20] <= 1'b1;
		wait_cyc(1);
		check({31'h0, wake_req}, 32'h00000000);
		stop_mode       <= 1'b0;
		shutoff_mode    <= 1'b1;
		ext_val[8]      <= 1'b1;
		wait_cyc(1);
		check({31'h0, shutoff_wake}, 32'h00000001);
		shutoff_mode <= 1'b0;
		wait_cyc(1);
		check({31'h0, shutoff_wake}, 32'h00000000);
		$display("wake done");
	endtask : t_wake

	task t_retain;
		wr(gpx_pkg::OFF_DIR, 32'h00010007);
		wr(gpx_pkg::OFF_DOUT, 32'h00000000);
		deep_sleep_mode <= 1'b1;
		wr(gpx_pkg::OFF_DOUT, 32'h00010001);
		wait_cyc(3);
		check({30'h0, pad_out[16], pad_out[0]}, 32'h00000001);
		rdchk(gpx_pkg::OFF_STATUS, 32'h00000001);
		deep_sleep_mode <= 1'b0;
		wait_cyc(3);
		check({31'h0, pad_out[16]}, 32'h00000001);
		$display("retention done");
	endtask : t_retain

	initial
	begin
		miscompares = 0;
		n_tests = 0;
		reset = 1'b1;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		per_out = 4'h0;
		per_oe = 4'h0;
		ext_val = 31'h00000000;
		deep_sleep_mode = 1'b0;
		stop_mode = 1'b0;
		shutoff_mode = 1'b0;
		wait_cyc(20);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		t_drive();
		t_irq();
		t_filter();
		t_route();
		t_wake();
		t_retain();
		finish_test();
	end
endmodule : test_gpx_port
